/* File: design/spf_pkg.sv */
/*
 Constants, register map, field layout and bus carriers for the serial port
 flag and pin block. Assumes a 10 MHz module clock and an AXI4-Lite master.
*/
package spf_pkg;
   localparam int CLK_HZ     = 10_000_000;
   localparam int BAUD_HZ    = 9600;
   localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
   localparam logic [10:0] BIT_LAST = 11'(BIT_CYCLES - 1);
   localparam logic [10:0] BIT_HALF = 11'(BIT_CYCLES / 2);
   // Register byte addresses
   localparam logic [31:0] ADDR_CTRL1 = 32'h0000_0000;
   localparam logic [31:0] ADDR_CTRL2 = 32'h0000_0004;
   localparam logic [31:0] ADDR_STAT1 = 32'h0000_0008;
   localparam logic [31:0] ADDR_DATAH = 32'h0000_000c;
   localparam logic [31:0] ADDR_DATAL = 32'h0000_0010;
   localparam logic [31:0] ADDR_PURD  = 32'h0000_0014;
   localparam logic [31:0] ADDR_PORT  = 32'h0000_0018;
   localparam logic [31:0] ADDR_DIR   = 32'h0000_001c;
   // One-hot select positions
   localparam int SEL_CTRL1 = 0;
   localparam int SEL_CTRL2 = 1;
   localparam int SEL_STAT1 = 2;
   localparam int SEL_DATAH = 3;
   localparam int SEL_DATAL = 4;
   localparam int SEL_PURD  = 5;
   localparam int SEL_PORT  = 6;
   localparam int SEL_DIR   = 7;
   // Field positions
   localparam int C1_FRAME9 = 0;
   localparam int C1_ODRAIN = 1;
   localparam int C2_TXE_IE = 7;
   localparam int C2_TXC_IE = 6;
   localparam int C2_RX_IE  = 5;
   localparam int C2_IDL_IE = 4;
   localparam int C2_TX_EN  = 3;
   localparam int C2_RX_EN  = 2;
   localparam int C2_STBY   = 1;
   localparam int PD_PULLUP = 0;
   localparam int PD_REDUCE = 1;
   localparam int PIN_TX    = 1;
   localparam int PIN_RX    = 0;
   // Reset values
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [7:0] PURD_RST  = 8'h00;
   localparam logic [7:0] PORT_RST  = 8'h00;
   localparam logic [7:0] DIR_RST   = 8'h00;
   // Frame and idle bit counts, last data bit indices and bus response codes
   localparam logic [3:0] IDLE_BITS_8 = 4'ha;
   localparam logic [3:0] IDLE_BITS_9 = 4'hb;
   localparam logic [3:0] DATA_LAST_8 = 4'h7;
   localparam logic [3:0] DATA_LAST_9 = 4'h8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10,
      RX_STOP  = 2'b11
   } spf_rx_st_t;

   typedef struct packed {
      logic [31:0] awaddr;
      logic        awvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        wvalid;
      logic        bready;
      logic [31:0] araddr;
      logic        arvalid;
      logic        rready;
   } spf_axil_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic [1:0]  bresp;
      logic        bvalid;
      logic        arready;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        rvalid;
   } spf_axil_rsp_t;
endpackage

/* File: design/spf_serial_port.sv */
/*
 Serial port flags and pins: AXI4-Lite register slave, minimal transmit and
 receive shifters, status flags with read/access clear sequences except transmit complete, which any DATAL write clears,
 interrupt request, and the two serial pins with direction, pullup, drive
 and open-drain control. Assumes pins are resolved to wire levels outside.
*/
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module spf_serial_port
   import spf_pkg::*;
(
   input  wire logic          clock_i,
   input  wire logic          rst_b_i,
   input  wire spf_axil_req_t axi_req_i,
   output spf_axil_rsp_t      axi_rsp_o,
   input  wire logic          tx_pin_i,
   output logic               tx_pin_o,
   output logic               tx_pin_oe_o,
   input  wire logic          rx_pin_i,
   output logic               rx_pin_o,
   output logic               rx_pin_oe_o,
   output logic               pullup_en_o,
   output logic               reduced_drive_o,
   output logic               irq_req_o
);
   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0]  bresp_ff, rresp_ff;
   logic [31:0] rdata_ff, waddr_ff, wdata_ff;
   logic        wstrb0_ff, aw_have_ff, w_have_ff;
   logic [7:0]  ctrl1_ff, ctrl2_ff, purd_ff, port_ff, dir_ff;
   logic        rx_standby_ff, tx_bit8_ff;
   logic        tx_empty_flag_ff, tx_complete_flag_ff, rx_full_flag_ff;
   logic        idle_flag_ff, overrun_flag_ff, idle_allow_ff;
   logic [4:0]  arm_ff;
   logic [7:0]  tx_hold_ff;
   logic        tx_pend_ff;
   logic [10:0] tx_shift_ff;
   logic [3:0]  tx_left_ff;
   logic [10:0] tx_div_ff;
   logic [1:0]  pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_filt_ff;
   spf_rx_st_t  rx_st_ff;
   logic [10:0] rx_div_ff;
   logic [3:0]  rx_bit_ff, idle_cnt_ff;
   logic [8:0]  rx_sh_ff, rx_data_ff;
   logic        tx_pin_ff, tx_oe_ff, rx_pin_ff, rx_oe_ff, irq_ff;

   // ****************************************************************
   // Address decode
   // ****************************************************************
   function automatic logic [7:0] spf_decode(input logic [31:0] a);
      logic [7:0] s;
      s = 8'h00;
      if (a == ADDR_CTRL1) s[SEL_CTRL1] = 1'b1;
      else if (a == ADDR_CTRL2) s[SEL_CTRL2] = 1'b1;
      else if (a == ADDR_STAT1) s[SEL_STAT1] = 1'b1;
      else if (a == ADDR_DATAH) s[SEL_DATAH] = 1'b1;
      else if (a == ADDR_DATAL) s[SEL_DATAL] = 1'b1;
      else if (a == ADDR_PURD) s[SEL_PURD] = 1'b1;
      else if (a == ADDR_PORT) s[SEL_PORT] = 1'b1;
      else if (a == ADDR_DIR) s[SEL_DIR] = 1'b1;
      return s;
   endfunction

   wire       aw_hs  = axi_req_i.awvalid & awready_ff;
   wire       w_hs   = axi_req_i.wvalid & wready_ff;
   wire       b_hs   = bvalid_ff & axi_req_i.bready;
   wire       ar_hs  = axi_req_i.arvalid & arready_ff;
   wire       r_hs   = rvalid_ff & axi_req_i.rready;
   wire       wr_go  = aw_have_ff & w_have_ff & ~bvalid_ff;
   wire [7:0] w_sel  = spf_decode(waddr_ff);
   wire [7:0] r_sel  = spf_decode(axi_req_i.araddr);
   wire       wr_en  = wr_go & wstrb0_ff;
   wire [7:0] wbyte  = wdata_ff[7:0];
   wire       wr_dl  = wr_en & w_sel[SEL_DATAL];
   wire       rd_st  = ar_hs & r_sel[SEL_STAT1];
   wire       rd_dl  = ar_hs & r_sel[SEL_DATAL];

   // ****************************************************************
   // Pin input synchronisers, filtered once two late stages agree
   // ****************************************************************
   wire [1:0] pin_raw = {tx_pin_i, rx_pin_i};
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pin_s1_ff <= 2'h3;
         pin_s2_ff <= 2'h3;
         pin_s3_ff <= 2'h3;
      end
      else
      begin
         pin_s1_ff <= pin_raw;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : g_filt
         always_ff @(posedge clock_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
               pin_filt_ff[g] <= 1'b1;
            else if (pin_s2_ff[g] == pin_s3_ff[g])
               pin_filt_ff[g] <= pin_s3_ff[g];
         end
      end
   endgenerate

   // ****************************************************************
   // Transmitter
   // ****************************************************************
   wire       frame9    = ctrl1_ff[C1_FRAME9];
   wire       tx_en     = ctrl2_ff[C2_TX_EN];
   wire       tx_busy   = (tx_left_ff != 4'h0);
   wire       tx_tick   = (tx_div_ff == BIT_LAST);
   wire       tx_load   = tx_pend_ff & ~tx_busy & tx_en;
   wire       tx_line   = tx_busy ? tx_shift_ff[0] : 1'b1;
   wire [10:0] tx_frame = frame9 ? {1'b1, tx_bit8_ff, tx_hold_ff, 1'b0}
                                 : {2'b11, tx_hold_ff, 1'b0};
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         tx_shift_ff <= 11'h7ff;
         tx_left_ff  <= 4'h0;
         tx_div_ff   <= 11'h000;
      end
      else if (tx_load)
      begin
         tx_shift_ff <= tx_frame;
         tx_left_ff  <= frame9 ? IDLE_BITS_9 : IDLE_BITS_8;
         tx_div_ff   <= 11'h000;
      end
      else if (tx_busy)
      begin
         tx_div_ff <= tx_tick ? 11'h000 : tx_div_ff + 11'h001;
         if (tx_tick)
         begin
            tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
            tx_left_ff  <= tx_left_ff - 4'h1;
         end
      end
   end

   // ****************************************************************
   // Receiver and idle detector
   // ****************************************************************
   wire       rx_line   = pin_filt_ff[PIN_RX];
   wire       rx_en     = ctrl2_ff[C2_RX_EN];
   wire       rx_tick   = (rx_div_ff == BIT_LAST);
   wire [3:0] data_last = frame9 ? DATA_LAST_9 : DATA_LAST_8;
   wire [3:0] idle_goal = frame9 ? IDLE_BITS_9 : IDLE_BITS_8;
   wire       stop_ok   = (rx_st_ff == RX_STOP) & rx_tick & rx_line;
   wire       rx_keep   = stop_ok & ~rx_standby_ff;
   wire       ovr_set   = rx_keep & rx_full_flag_ff;
   wire       rx_set    = rx_keep & ~rx_full_flag_ff;
   wire [8:0] rx_word   = frame9 ? rx_sh_ff : {1'b0, rx_sh_ff[8:1]};
   wire       idle_hit  = (rx_st_ff == RX_IDLE) & rx_en & rx_tick & rx_line
                          & (idle_cnt_ff == idle_goal - 4'h1);
   wire       wake_idle = idle_hit & rx_standby_ff;
   wire       idle_set  = idle_hit & ~rx_standby_ff & idle_allow_ff;

   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rx_st_ff  <= RX_IDLE;
         rx_div_ff <= 11'h000;
         rx_bit_ff <= 4'h0;
         rx_sh_ff  <= 9'h000;
      end
      else
      begin
         rx_div_ff <= rx_tick ? 11'h000 : rx_div_ff + 11'h001;
         case (rx_st_ff)
            RX_IDLE:
               if (rx_en && !rx_line)
               begin
                  rx_st_ff  <= RX_START;
                  rx_div_ff <= 11'h000;
               end
            RX_START:
               if (rx_div_ff == BIT_HALF)
               begin
                  rx_st_ff  <= rx_line ? RX_IDLE : RX_DATA;
                  rx_div_ff <= 11'h000;
                  rx_bit_ff <= 4'h0;
               end
            RX_DATA:
               if (rx_tick)
               begin
                  rx_sh_ff  <= {rx_line, rx_sh_ff[8:1]};
                  rx_bit_ff <= rx_bit_ff + 4'h1;
                  if (rx_bit_ff == data_last)
                     rx_st_ff <= RX_STOP;
               end
            RX_STOP:
               if (rx_tick)
                  rx_st_ff <= RX_IDLE;
            default:
               rx_st_ff <= RX_IDLE;
         endcase
      end
   end

   // Counts whole bit times of mark after a stop bit or since the receiver was enabled
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         idle_cnt_ff <= 4'h0;
      else if (rx_st_ff != RX_IDLE || !rx_line || !rx_en)
         idle_cnt_ff <= 4'h0;
      else if (rx_tick && idle_cnt_ff != idle_goal)
         idle_cnt_ff <= idle_cnt_ff + 4'h1;
   end

   // Held frame is replaced only when no overrun
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rx_data_ff <= 9'h000;
      else if (rx_set)
         rx_data_ff <= rx_word;
   end

   // ****************************************************************
   // Flags, arming and interrupt request
   // ****************************************************************
   wire [4:0] flags    = {overrun_flag_ff, idle_flag_ff, rx_full_flag_ff,
                          tx_complete_flag_ff, tx_empty_flag_ff};
   wire [4:0] arm_drop = {{3{rd_dl}}, {2{wr_dl}}};
   wire [4:0] nxt_arm  = (arm_ff & ~arm_drop) | (rd_st ? flags : 5'h00);
   wire       txe_clr  = wr_dl & arm_ff[0];
   wire       txc_set  = tx_empty_flag_ff & ~tx_busy & ~tx_pend_ff & ~wr_dl;
   wire       txc_clr  = wr_dl | (wr_dl & arm_ff[1] & ~tx_busy);
   wire       rxf_clr  = rd_dl & arm_ff[2];
   wire       idl_clr  = rd_dl & arm_ff[3];
   wire       ovr_clr  = rd_dl & arm_ff[4];
   wire       nxt_irq  = (tx_empty_flag_ff & ctrl2_ff[C2_TXE_IE])
                       | (tx_complete_flag_ff & ctrl2_ff[C2_TXC_IE])
                       | ((rx_full_flag_ff | overrun_flag_ff) & ctrl2_ff[C2_RX_IE])
                       | (idle_flag_ff & ctrl2_ff[C2_IDL_IE]);

   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         tx_empty_flag_ff    <= 1'b1;
         tx_complete_flag_ff <= 1'b1;
         rx_full_flag_ff     <= 1'b0;
         idle_flag_ff        <= 1'b0;
         overrun_flag_ff     <= 1'b0;
         idle_allow_ff       <= 1'b1;
         arm_ff              <= 5'h00;
         irq_ff              <= 1'b0;
      end
      else
      begin
         tx_empty_flag_ff    <= tx_load | (tx_empty_flag_ff & ~txe_clr);
         tx_complete_flag_ff <= txc_set | (tx_complete_flag_ff & ~txc_clr);
         rx_full_flag_ff     <= rx_set | (rx_full_flag_ff & ~rxf_clr);
         idle_flag_ff        <= idle_set | (idle_flag_ff & ~idl_clr);
         overrun_flag_ff     <= ovr_set | (overrun_flag_ff & ~ovr_clr);
         idle_allow_ff       <= rx_set | (idle_allow_ff & ~idle_set);
         arm_ff              <= nxt_arm;
         irq_ff              <= nxt_irq;
      end
   end

   // ****************************************************************
   // Register file
   // ****************************************************************
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ctrl1_ff      <= CTRL1_RST;
         ctrl2_ff      <= CTRL2_RST;
         purd_ff       <= PURD_RST;
         port_ff       <= PORT_RST;
         dir_ff        <= DIR_RST;
         rx_standby_ff <= 1'b0;
         tx_bit8_ff    <= 1'b0;
         tx_hold_ff    <= 8'h00;
         tx_pend_ff    <= 1'b0;
      end
      else
      begin
         if (wr_en && w_sel[SEL_CTRL1]) ctrl1_ff <= wbyte;
         if (wr_en && w_sel[SEL_CTRL2]) ctrl2_ff <= wbyte;
         if (wr_en && w_sel[SEL_PURD]) purd_ff <= wbyte;
         if (wr_en && w_sel[SEL_PORT]) port_ff <= wbyte;
         if (wr_en && w_sel[SEL_DIR]) dir_ff <= wbyte;
         if (wr_en && w_sel[SEL_DATAH]) tx_bit8_ff <= wbyte[6];
         if (wr_en && w_sel[SEL_CTRL2]) rx_standby_ff <= wbyte[C2_STBY];
         else if (wake_idle) rx_standby_ff <= 1'b0;
         if (wr_dl) tx_hold_ff <= wbyte;
         tx_pend_ff <= wr_dl | (tx_pend_ff & ~tx_load);
      end
   end

   logic [7:0] rd_mux;
   always_comb
   begin
      rd_mux = 8'h00;
      if (r_sel[SEL_CTRL1]) rd_mux = ctrl1_ff;
      else if (r_sel[SEL_CTRL2]) rd_mux = {ctrl2_ff[7:2], rx_standby_ff, ctrl2_ff[0]};
      else if (r_sel[SEL_STAT1]) rd_mux = {flags[0], flags[1], flags[2], flags[3],
                                           flags[4], 3'h0};
      else if (r_sel[SEL_DATAH]) rd_mux = {rx_data_ff[8], tx_bit8_ff, 6'h00};
      else if (r_sel[SEL_DATAL]) rd_mux = rx_data_ff[7:0];
      else if (r_sel[SEL_PURD]) rd_mux = purd_ff;
      else if (r_sel[SEL_PORT]) rd_mux = {6'h00, pin_filt_ff};
      else if (r_sel[SEL_DIR]) rd_mux = dir_ff;
   end

   // ****************************************************************
   // AXI4-Lite handshakes
   // ****************************************************************
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         aw_have_ff <= 1'b0;
         w_have_ff  <= 1'b0;
         waddr_ff   <= 32'h0000_0000;
         wdata_ff   <= 32'h0000_0000;
         wstrb0_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
      end
      else
      begin
         if (aw_hs) {awready_ff, aw_have_ff, waddr_ff} <= {2'b01, axi_req_i.awaddr};
         if (w_hs) {wready_ff, w_have_ff, wdata_ff} <= {2'b01, axi_req_i.wdata};
         if (w_hs) wstrb0_ff <= axi_req_i.wstrb[0];
         if (wr_go) {aw_have_ff, w_have_ff, bvalid_ff} <= 3'b001;
         if (wr_go) bresp_ff <= (w_sel == 8'h00) ? RESP_SLVERR : RESP_OKAY;
         if (b_hs) {awready_ff, wready_ff, bvalid_ff} <= 3'b110;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= RESP_OKAY;
      end
      else if (ar_hs)
      begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rdata_ff   <= {24'h00_0000, rd_mux};
         rresp_ff   <= (r_sel == 8'h00) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (r_hs)
         {arready_ff, rvalid_ff} <= 2'b10;
   end

   // ****************************************************************
   // Pin drivers
   // ****************************************************************
   wire od      = ctrl1_ff[C1_ODRAIN];
   wire tx_val  = tx_en ? tx_line : port_ff[PIN_TX];
   wire rx_val  = port_ff[PIN_RX];
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         tx_pin_ff <= 1'b1;
         tx_oe_ff  <= 1'b0;
         rx_pin_ff <= 1'b0;
         rx_oe_ff  <= 1'b0;
      end
      else
      begin
         tx_pin_ff <= tx_val;
         tx_oe_ff  <= dir_ff[PIN_TX] & (~od | ~tx_val);
         rx_pin_ff <= rx_val;
         rx_oe_ff  <= dir_ff[PIN_RX] & (~od | ~rx_val);
      end
   end

   assign tx_pin_o        = tx_pin_ff;
   assign tx_pin_oe_o     = tx_oe_ff;
   assign rx_pin_o        = rx_pin_ff;
   assign rx_pin_oe_o     = rx_oe_ff;
   assign pullup_en_o     = purd_ff[PD_PULLUP];
   assign reduced_drive_o = purd_ff[PD_REDUCE];
   assign irq_req_o       = irq_ff;
   assign axi_rsp_o       = '{awready: awready_ff, wready: wready_ff, bresp: bresp_ff,
                              bvalid: bvalid_ff, arready: arready_ff, rdata: rdata_ff,
                              rresp: rresp_ff, rvalid: rvalid_ff};

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   sequence seq_arm_rxf;
      rd_st && rx_full_flag_ff && !rd_dl;
   endsequence
   sequence seq_read_dl;
      rd_dl && !rx_set;
   endsequence

   AST_TX_IDLE_HIGH: assert property (tx_complete_flag_ff |-> tx_line == 1'b1)
      else $error("line not idle high while complete");
   AST_TXC_SET: assert property (txc_set |=> tx_complete_flag_ff)
      else $error("complete flag failed to set");
   AST_TXC_QUEUE: assert property (wr_dl |=> !tx_complete_flag_ff)
      else $error("complete flag survived a queued frame");
   AST_TXE_LOAD: assert property (tx_load |=> tx_empty_flag_ff && tx_busy)
      else $error("empty flag not set on shifter load");
   AST_IRQ_MAP: assert property (irq_req_o == $past(nxt_irq))
      else $error("interrupt request mismatch");
   AST_RXF_CLEAR: assert property (seq_arm_rxf ##[1:20] seq_read_dl |=>
                                   !rx_full_flag_ff)
      else $error("receive-full not cleared by sequence");
   AST_OVR_KEEP: assert property (ovr_set |=> $stable(rx_data_ff) && overrun_flag_ff)
      else $error("held data changed on overrun");
   AST_IDLE_GATE: assert property ($rose(idle_flag_ff) |-> $past(idle_allow_ff))
      else $error("idle set without intervening frame");
   AST_UNARMED: assert property (rd_dl && !arm_ff[2] && rx_full_flag_ff |=>
                                 rx_full_flag_ff)
      else $error("unarmed flag was cleared");
   AST_OPEN_DRAIN: assert property (tx_oe_ff && $past(od) |-> !tx_pin_ff)
      else $error("open-drain pin drove high");
endmodule // spf_serial_port

/* File: testbench/spf_remote.sv */
/*
 Remote serial device model driving the receive line of the block.
 Assumes the block's clock and the package bit timing.
*/
`timescale 1ns/1ps
module spf_remote
   import spf_pkg::*;
(
   input  wire logic clock_i,
   output logic      line_o
);
   initial line_o = 1'b1;
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         line_o <= f[i];
         repeat (BIT_CYCLES) @(posedge clock_i);
      end
   endtask
endmodule // spf_remote

/* File: testbench/tb_serial_port_flags_and_pins.sv */
/*
 Self-checking bench for the serial port flag and pin block.
 Assumes the package map and a pulled-up transmit pin.
*/
`timescale 1ns/1ps
module tb_serial_port_flags_and_pins
   import spf_pkg::*;
;
   logic          clock_i;
   logic          rst_b_i;
   spf_axil_req_t req;
   spf_axil_rsp_t rsp;
   logic          tx_o, tx_oe, rx_o, rx_oe, pu, rdr, irq, rx_line;
   int            n_errors = 0;
   int            total_checks = 0;
   int            seed = 32'h3157;
   logic [31:0]   v, resp;
   logic [7:0]    a, b;
   wire           tx_w = tx_oe ? tx_o : 1'b1;
   wire           rx_w = rx_oe ? rx_o : rx_line;
   spf_serial_port i_dut(.clock_i(clock_i), .rst_b_i(rst_b_i), .axi_req_i(req),
      .axi_rsp_o(rsp), .tx_pin_i(tx_w), .tx_pin_o(tx_o), .tx_pin_oe_o(tx_oe),
      .rx_pin_i(rx_w), .rx_pin_o(rx_o), .rx_pin_oe_o(rx_oe), .pullup_en_o(pu),
      .reduced_drive_o(rdr), .irq_req_o(irq));
   spf_remote i_rem(.clock_i(clock_i), .line_o(rx_line));
   initial
   begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task conclude;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task wr(input logic [31:0] ad, input logic [31:0] d);
      @(posedge clock_i);
      req.awaddr  <= ad;
      req.awvalid <= 1'b1;
      req.wdata   <= d;
      req.wvalid  <= 1'b1;
      req.bready  <= 1'b1;
      do
      begin
         @(posedge clock_i);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
      resp = 32'(rsp.bresp);
      @(posedge clock_i);
   endtask
   task rd(input logic [31:0] ad);
      @(posedge clock_i);
      req.araddr  <= ad;
      req.arvalid <= 1'b1;
      req.rready  <= 1'b1;
      do
      begin
         @(posedge clock_i);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      req.rready <= 1'b0;
      v = rsp.rdata;
      resp = 32'(rsp.rresp);
   endtask
   //*****************************************
   // Tests
   //*****************************************
   initial
   begin
      rst_b_i = 1'b0;
      req = '0;
      req.wstrb = 4'hf;
      repeat (12) @(posedge clock_i);
      rst_b_i <= 1'b1;
      rd(ADDR_STAT1); chk(v, 32'hc0);
      rd(ADDR_CTRL1); chk(v, 32'h0);
      rd(ADDR_PURD); chk(v, 32'h0);
      rd(32'h40); chk(resp, 32'(RESP_SLVERR));
      $display("test reset done");
      wr(ADDR_PURD, 32'h2); chk({pu, rdr}, 32'h1);
      wr(ADDR_PURD, 32'h1); chk({pu, rdr}, 32'h2);
      wr(32'h40, 32'h1); chk(resp, 32'(RESP_SLVERR));
      wr(ADDR_DIR, 32'h1); wr(ADDR_PORT, 32'h0);
      repeat (8) @(posedge clock_i);
      rd(ADDR_PORT); chk(v, 32'h2);
      wr(ADDR_DIR, 32'h2); wr(ADDR_PORT, 32'h2);
      chk({tx_oe, tx_o}, 32'h3);
      wr(ADDR_CTRL1, 32'h2); chk(tx_oe, 1'b0);
      wr(ADDR_PORT, 32'h0); chk({tx_oe, tx_o}, 32'h2);
      wr(ADDR_PORT, 32'h2); wr(ADDR_CTRL1, 32'h0);
      $display("test pins done");
      a = 8'($random(seed));
      b = a ^ 8'($random(seed) | 1);
      wr(ADDR_CTRL2, 32'h24);
      i_rem.send(a);
      i_rem.send(b);
      repeat (11 * BIT_CYCLES) @(posedge clock_i);
      chk(irq, 1'b1);
      rd(ADDR_STAT1); chk(v, 32'hf8);
      rd(ADDR_DATAL); chk(v, 32'(a));
      rd(ADDR_STAT1); chk(v, 32'hc0);
      chk(irq, 1'b0);
      $display("test receive done");
      wr(ADDR_CTRL2, 32'h0c); wr(ADDR_DATAL, 32'(b));
      rd(ADDR_STAT1); chk(v & 32'h40, 32'h0);
      repeat (12 * BIT_CYCLES) @(posedge clock_i);
      rd(ADDR_STAT1); chk(v, 32'hc0);
      chk(tx_o, 1'b1);
      wr(ADDR_CTRL2, 32'h80); chk(irq, 1'b1);
      $display("test transmit done");
      conclude();
   end
   initial
   begin
      repeat (80000) @(posedge clock_i);
      n_errors++;
      conclude();
   end
endmodule // tb_serial_port_flags_and_pins
